//--- common/tsu_pkg.sv
// Purpose: Shared constants and types of the triple slave unit
// Assumes: 7-bit addressing only, one RAM holding all three buffers
// Notes: Buffer bases and event codes are internal layout choices
`default_nettype none
package tsu_pkg;
	// Page length select codes
	localparam logic [1:0] PL_8 = 2'h0;
	localparam logic [1:0] PL_16 = 2'h1;
	localparam logic [1:0] PL_FULL = 2'h2;
	localparam logic [7:0] PAGE8_MASK = 8'h07;
	localparam logic [7:0] PAGE16_MASK = 8'h0F;
	localparam logic [7:0] BUF12_MASK = 8'hFF;
	// RAM layout: one byte array, three fixed buffers
	localparam int RAM_BYTES = 640;
	localparam logic [9:0] BUF1_BASE = 10'h000;
	localparam logic [9:0] BUF2_BASE = 10'h100;
	localparam logic [9:0] BUF3_BASE = 10'h200;
	// Bit slot counter values on the link
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] AFTER_ACK = 4'h9;
	localparam logic [3:0] LAST_TX = 4'h7;
	// Reset values
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [7:0] CNT_RST = 8'h00;
	// Events passed from the link domain to the CPU domain
	typedef enum logic [2:0] {
		EV_BADDR = 3'h0,
		EV_WDATA = 3'h1,
		EV_RFETCH = 3'h2,
		EV_RNEXT = 3'h3,
		EV_END = 3'h4
	} tsu_ev_t;
	typedef enum logic [5:0] {
		L_IDLE = 6'h01,
		L_ADDR = 6'h02,
		L_BADDR = 6'h04,
		L_WDATA = 6'h08,
		L_RDATA = 6'h10,
		L_SKIP = 6'h20
	} tsu_link_t;
	typedef enum logic [3:0] {
		D_IDLE = 4'h1,
		D_WR = 4'h2,
		D_RD1 = 4'h4,
		D_RD2 = 4'h8
	} tsu_dma_t;
endpackage : tsu_pkg
`default_nettype wire

//--- logic/tsu_triple_slave.sv
// Purpose: Slave-only I2C unit with three addresses and DMA to RAM buffers
// Assumes: link_clk oversamples SCL and SDA; CPU holds its access while cpu_stall
// Notes: Bus engine on link_clk, RAM and flags on clk, toggle crossings between
//
// Functional notes
// - Three 7-bit slave addresses, each answering only when its enable bit is set.
// - Slaves one and two share one interrupt line; slave three has its own.
// - Fixed buffers: two of 256 bytes, one of 128 bytes.
// - Read-done and write-done flags per slave; interrupt only when enabled.
// - Two-bit page length selects 8, 16 or full buffer for all slaves.
// - Full page means 256 bytes for slaves one, two and 128 for three.
// - Master writes wrap within the configured page.
// - Master reads wrap only at the end of the whole buffer.
// - Byte counter wraps at 256 for every slave.
// - A DMA request per received data byte and before each transmitted byte.
// - DMA holds the CPU at most two cycles per access, then releases RAM.
// - Write locks protect buffers one and two from master writes only.
// - Protected writes are acked, address loaded, data dropped, counters advance.
// - Protected writes raise no interrupt and do not set write hold.
// - Read fetches a word: first byte to shifter, next byte to shadow.
// - Second byte in a message comes from the shadow; pairing repeats.
// - Word mode: CPU even byte shadowed, odd byte written, shadow written next cycle.
// - DMA held off during the shadow write-back cycle.
// - Word mode clears itself after the word update.
// - Writing one to write hold keeps it; writing zero clears it.
// - Every unprotected master write with a data byte sets write hold, suspending the unit.
// - Done flags set at stop or restart; cleared by status read when idle.
`timescale 1ns/1ps
`default_nettype none
module tsu_triple_slave #(
	parameter int BUF3_BYTES = 128
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	input wire logic [7:0] slave_one_address_reg,
	input wire logic [7:0] slave_two_address_reg,
	input wire logic [7:0] slave_three_address_reg,
	input wire logic [1:0] page_length_select,
	input wire logic buffer_one_write_lock,
	input wire logic buffer_two_write_lock,
	input wire logic [2:0] read_irq_en,
	input wire logic [2:0] write_irq_en,
	input wire logic cr2_wr,
	input wire logic cr2_word_mode,
	input wire logic cr2_write_hold,
	input wire logic status_rd,
	input wire logic cpu_we,
	input wire logic [9:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	output logic cpu_stall,
	output logic dma_req,
	output logic [2:0] read_done_flag,
	output logic [2:0] write_done_flag,
	output logic write_hold_flag,
	output logic word_mode,
	output logic bus_busy,
	output logic irq_slaves12,
	output logic irq_slave3
);
	initial begin
		if (BUF3_BYTES < 16 || BUF3_BYTES > 256 || (BUF3_BYTES & (BUF3_BYTES - 1)) != 0)
			$error("BUF3_BYTES must be a power of two from 16 to 256");
	end
	localparam logic [7:0] BUF3_MASK = 8'(BUF3_BYTES - 1);

	function automatic logic [9:0] base_of(input logic [1:0] s);
		return (s == 2'h0) ? tsu_pkg::BUF1_BASE : (s == 2'h1) ? tsu_pkg::BUF2_BASE : tsu_pkg::BUF3_BASE;
	endfunction : base_of
	function automatic logic [7:0] buf_mask(input logic [1:0] s);
		return (s == 2'h2) ? BUF3_MASK : tsu_pkg::BUF12_MASK;
	endfunction : buf_mask
	function automatic logic [7:0] wrap_inc(input logic [7:0] a, input logic [7:0] m);
		return (a & ~m) | ((a + 8'h01) & m);
	endfunction : wrap_inc

	// ==========================================================
	// Link domain: resets, enables and pin synchronisers
	logic [1:0] lrst_q, lce_q;
	logic [2:0] scl_s_q, sda_s_q, rsp_s_q;
	logic [24:0] cfg_s1_q, cfg_s2_q;
	logic lrst, lce;
	logic rsp_tgl_q;
	logic [7:0] rsp_dat_q;
	logic hold_q;
	assign lrst = lrst_q[1];
	assign lce = lce_q[1];
	always_ff @(posedge link_clk) begin
		lrst_q <= {lrst_q[0], rst};
		lce_q <= {lce_q[0], ce};
	end
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			rsp_s_q <= 3'h0;
			cfg_s1_q <= 25'h0000000;
			cfg_s2_q <= 25'h0000000;
		end else if (lce) begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
			rsp_s_q <= {rsp_s_q[1:0], rsp_tgl_q};
			cfg_s1_q <= {hold_q, slave_three_address_reg, slave_two_address_reg,
				slave_one_address_reg};
			cfg_s2_q <= cfg_s1_q;
		end
	end

	// ==========================================================
	// Link domain: bit engine
	tsu_pkg::tsu_link_t ls_q, ls_d;
	logic [3:0] bc_q, bc_d;
	logic [7:0] sh_q, sh_d, tx_q, tx_d, rsp_l_q, rsp_l_d, ev_dat_q, ev_dat_d;
	logic oe_n_q, oe_n_d, scl_f_q, scl_f_d, sda_f_q, sda_f_d;
	logic rd_did_q, rd_did_d, wr_did_q, wr_did_d, busy_l_q, busy_l_d, ev_tgl_q, ev_tgl_d;
	logic [1:0] sl_q, sl_d, ev_sl_q, ev_sl_d, hit_idx;
	tsu_pkg::tsu_ev_t ev_kind_q, ev_kind_d;
	logic hit, start_c, stop_c, rise, fall;

	always_comb begin
		hit = 1'b0;
		hit_idx = 2'h0;
		for (int i = 2; i >= 0; i--) begin
			if (cfg_s2_q[8*i] && cfg_s2_q[8*i+1 +: 7] == sh_q[7:1] && !cfg_s2_q[24]) begin
				hit = 1'b1;
				hit_idx = 2'(i);
			end
		end
	end

	always_comb begin
		ls_d = ls_q;
		bc_d = bc_q;
		sh_d = sh_q;
		tx_d = tx_q;
		oe_n_d = oe_n_q;
		sl_d = sl_q;
		rd_did_d = rd_did_q;
		wr_did_d = wr_did_q;
		ev_tgl_d = ev_tgl_q;
		ev_kind_d = ev_kind_q;
		ev_sl_d = ev_sl_q;
		ev_dat_d = ev_dat_q;
		rsp_l_d = (rsp_s_q[2] != rsp_s_q[1]) ? rsp_dat_q : rsp_l_q;
		scl_f_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
		sda_f_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
		start_c = scl_f_q & scl_f_d & sda_f_q & ~sda_f_d;
		stop_c = scl_f_q & scl_f_d & ~sda_f_q & sda_f_d;
		rise = ~scl_f_q & scl_f_d;
		fall = scl_f_q & ~scl_f_d;
		if (start_c || stop_c) begin
			if (rd_did_q || wr_did_q) begin
				ev_tgl_d = ~ev_tgl_q;
				ev_kind_d = tsu_pkg::EV_END;
				ev_sl_d = sl_q;
				ev_dat_d = {6'h00, wr_did_q, rd_did_q};
			end
			rd_did_d = 1'b0;
			wr_did_d = 1'b0;
			oe_n_d = 1'b1;
			bc_d = 4'h0;
			ls_d = start_c ? tsu_pkg::L_ADDR : tsu_pkg::L_IDLE;
		end else if (rise) begin
			if (bc_q < tsu_pkg::ACK_SLOT)
				sh_d = {sh_q[6:0], sda_f_d};
			if (ls_q == tsu_pkg::L_RDATA && bc_q == tsu_pkg::ACK_SLOT) begin
				if (!sda_f_d) begin
					ev_tgl_d = ~ev_tgl_q;
					ev_kind_d = tsu_pkg::EV_RNEXT;
					ev_sl_d = sl_q;
				end else begin
					ls_d = tsu_pkg::L_SKIP;
				end
			end
			bc_d = bc_q + 4'h1;
		end else if (fall && bc_q == tsu_pkg::ACK_SLOT) begin
			unique case (ls_q)
				tsu_pkg::L_ADDR: begin
					if (hit) begin
						oe_n_d = 1'b0;
						sl_d = hit_idx;
						if (sh_q[0]) begin
							ev_tgl_d = ~ev_tgl_q;
							ev_kind_d = tsu_pkg::EV_RFETCH;
							ev_sl_d = hit_idx;
						end
					end else begin
						ls_d = tsu_pkg::L_SKIP;
					end
				end
				tsu_pkg::L_BADDR, tsu_pkg::L_WDATA: begin
					oe_n_d = 1'b0;
					ev_tgl_d = ~ev_tgl_q;
					ev_kind_d = (ls_q == tsu_pkg::L_BADDR) ? tsu_pkg::EV_BADDR : tsu_pkg::EV_WDATA;
					ev_sl_d = sl_q;
					ev_dat_d = sh_q;
					if (ls_q == tsu_pkg::L_WDATA)
						wr_did_d = 1'b1;
				end
				tsu_pkg::L_RDATA: oe_n_d = 1'b1;
				tsu_pkg::L_IDLE, tsu_pkg::L_SKIP: oe_n_d = 1'b1;
			endcase
		end else if (fall && bc_q == tsu_pkg::AFTER_ACK) begin
			bc_d = 4'h0;
			oe_n_d = 1'b1;
			unique case (ls_q)
				tsu_pkg::L_ADDR: ls_d = sh_q[0] ? tsu_pkg::L_RDATA : tsu_pkg::L_BADDR;
				tsu_pkg::L_BADDR: ls_d = tsu_pkg::L_WDATA;
				tsu_pkg::L_WDATA, tsu_pkg::L_RDATA, tsu_pkg::L_IDLE, tsu_pkg::L_SKIP: ;
			endcase
			if (ls_q == tsu_pkg::L_RDATA || (ls_q == tsu_pkg::L_ADDR && sh_q[0])) begin
				tx_d = rsp_l_d;
				oe_n_d = rsp_l_d[7];
				rd_did_d = 1'b1;
			end
		end else if (fall && ls_q == tsu_pkg::L_RDATA && bc_q != 4'h0 && bc_q <= tsu_pkg::LAST_TX) begin
			tx_d = {tx_q[6:0], 1'b1};
			oe_n_d = tx_q[6];
		end
		busy_l_d = (ls_d != tsu_pkg::L_IDLE);
	end

	always_ff @(posedge link_clk) begin
		if (lrst) begin
			ls_q <= tsu_pkg::L_IDLE;
			bc_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'hFF;
			oe_n_q <= 1'b1;
			sl_q <= 2'h0;
			rd_did_q <= 1'b0;
			wr_did_q <= 1'b0;
			busy_l_q <= 1'b0;
			ev_tgl_q <= 1'b0;
			ev_kind_q <= tsu_pkg::EV_END;
			ev_sl_q <= 2'h0;
			ev_dat_q <= 8'h00;
			rsp_l_q <= 8'hFF;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
		end else if (lce) begin
			ls_q <= ls_d;
			bc_q <= bc_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			oe_n_q <= oe_n_d;
			sl_q <= sl_d;
			rd_did_q <= rd_did_d;
			wr_did_q <= wr_did_d;
			busy_l_q <= busy_l_d;
			ev_tgl_q <= ev_tgl_d;
			ev_kind_q <= ev_kind_d;
			ev_sl_q <= ev_sl_d;
			ev_dat_q <= ev_dat_d;
			rsp_l_q <= rsp_l_d;
			scl_f_q <= scl_f_d;
			sda_f_q <= sda_f_d;
		end
	end
	assign sda_oe_n = oe_n_q;
	assign sda_o = 1'b0;

	// ==========================================================
	// CPU domain: event reception, DMA, word mode and flags
	logic [2:0] ev_s_q;
	logic [1:0] busy_s_q;
	logic [7:0] ram_q [tsu_pkg::RAM_BYTES];
	tsu_pkg::tsu_dma_t ds_q, ds_d;
	tsu_pkg::tsu_ev_t ek_q, ek_d;
	logic [1:0] esl_q, esl_d;
	logic [7:0] edat_q, edat_d, shr_q, shr_d, rsp_dat_d, wsh_q, wsh_d, rdata_q, rdata_d;
	logic [7:0] cur_q [3];
	logic [7:0] cur_d [3];
	logic [7:0] cnt_q [3];
	logic [7:0] cnt_d [3];
	logic [9:0] da_q, da_d, da2_q, da2_d, wsa_q, wsa_d;
	logic pend_q, pend_d, pair_q, pair_d, stall_q, stall_d, dreq_q, dreq_d, rsp_tgl_d;
	logic hold_d, wmode_q, wmode_d, wfull_q, wfull_d, wb_q, wb_d, irq12_q, irq12_d, irq3_q, irq3_d;
	logic [2:0] rdf_q, rdf_d, wrf_q, wrf_d, wrote_q, wrote_d;
	logic fire, cpu_ok, lock, a_we, b_we;
	logic [9:0] a_addr;
	logic [7:0] a_dat, m, off;

	always_ff @(posedge clk) begin
		if (rst) begin
			ev_s_q <= 3'h0;
			busy_s_q <= 2'h0;
		end else if (ce) begin
			ev_s_q <= {ev_s_q[1:0], ev_tgl_q};
			busy_s_q <= {busy_s_q[0], busy_l_q};
		end
	end
	assign fire = ev_s_q[2] ^ ev_s_q[1];

	always_comb begin
		ds_d = ds_q;
		ek_d = ek_q;
		esl_d = esl_q;
		edat_d = edat_q;
		shr_d = shr_q;
		rsp_dat_d = rsp_dat_q;
		rsp_tgl_d = rsp_tgl_q;
		wsh_d = wsh_q;
		wsa_d = wsa_q;
		da_d = da_q;
		da2_d = da2_q;
		cur_d = cur_q;
		cnt_d = cnt_q;
		pend_d = pend_q;
		pair_d = pair_q;
		dreq_d = 1'b0;
		hold_d = hold_q;
		wmode_d = wmode_q;
		wfull_d = wfull_q;
		wb_d = 1'b0;
		rdf_d = rdf_q;
		wrf_d = wrf_q;
		wrote_d = wrote_q;
		a_we = 1'b0;
		a_addr = da_q;
		a_dat = edat_q;
		b_we = 1'b0;
		m = buf_mask(esl_q);
		off = cur_q[esl_q];
		lock = (esl_q == 2'h0 && buffer_one_write_lock) || (esl_q == 2'h1 && buffer_two_write_lock);
		cpu_ok = cpu_we && !stall_q && (cpu_addr < 10'(tsu_pkg::RAM_BYTES));
		rdata_d = (cpu_addr < 10'(tsu_pkg::RAM_BYTES)) ? ram_q[cpu_addr] : 8'h00;
		if (status_rd && !busy_s_q[1]) begin
			rdf_d = 3'h0;
			wrf_d = 3'h0;
		end
		if (cr2_wr && !cr2_write_hold)
			hold_d = 1'b0;
		if (cpu_ok && wmode_q && !cpu_addr[0]) begin
			wsh_d = cpu_wdata;
			wsa_d = cpu_addr;
			wfull_d = 1'b1;
		end else if (cpu_ok) begin
			b_we = 1'b1;
			wb_d = wmode_q && wfull_q;
		end
		if (wb_q) begin
			a_we = 1'b1;
			a_addr = wsa_q;
			a_dat = wsh_q;
			wfull_d = 1'b0;
			wmode_d = 1'b0;
		end
		if (cr2_wr && cr2_word_mode)
			wmode_d = 1'b1;
		if (fire) begin
			pend_d = 1'b1;
			ek_d = ev_kind_q;
			esl_d = ev_sl_q;
			edat_d = ev_dat_q;
		end
		unique case (ds_q)
			tsu_pkg::D_IDLE: begin
				if (pend_q && !wb_q && !wb_d) begin
					pend_d = 1'b0;
					unique case (ek_q)
						tsu_pkg::EV_BADDR: cur_d[esl_q] = edat_q & m;
						tsu_pkg::EV_WDATA: begin
							dreq_d = 1'b1;
							da_d = base_of(esl_q) | {2'h0, off};
							if (!lock) begin
								ds_d = tsu_pkg::D_WR;
								wrote_d[esl_q] = 1'b1;
							end
							unique case (page_length_select)
								tsu_pkg::PL_8: cur_d[esl_q] = wrap_inc(off, tsu_pkg::PAGE8_MASK & m);
								tsu_pkg::PL_16: cur_d[esl_q] = wrap_inc(off, tsu_pkg::PAGE16_MASK & m);
								default: cur_d[esl_q] = wrap_inc(off, m);
							endcase
							cnt_d[esl_q] = cnt_q[esl_q] + 8'h01;
						end
						tsu_pkg::EV_RFETCH, tsu_pkg::EV_RNEXT: begin
							dreq_d = 1'b1;
							cur_d[esl_q] = wrap_inc(off, m);
							cnt_d[esl_q] = cnt_q[esl_q] + 8'h01;
							if (ek_q == tsu_pkg::EV_RNEXT && pair_q) begin
								rsp_dat_d = shr_q;
								rsp_tgl_d = ~rsp_tgl_q;
								pair_d = 1'b0;
							end else begin
								ds_d = tsu_pkg::D_RD1;
								da_d = base_of(esl_q) | {2'h0, off};
								da2_d = base_of(esl_q) | {2'h0, wrap_inc(off, m)};
							end
						end
						tsu_pkg::EV_END: begin
							pair_d = 1'b0;
							if (edat_q[0])
								rdf_d[esl_q] = 1'b1;
							if (edat_q[1] && wrote_q[esl_q]) begin
								wrf_d[esl_q] = 1'b1;
								hold_d = 1'b1;
							end
							wrote_d[esl_q] = 1'b0;
						end
						default: ;
					endcase
				end
			end
			tsu_pkg::D_WR: begin
				a_we = 1'b1;
				ds_d = tsu_pkg::D_IDLE;
			end
			tsu_pkg::D_RD1: begin
				rsp_dat_d = ram_q[da_q];
				ds_d = tsu_pkg::D_RD2;
			end
			tsu_pkg::D_RD2: begin
				shr_d = ram_q[da2_q];
				rsp_tgl_d = ~rsp_tgl_q;
				pair_d = 1'b1;
				ds_d = tsu_pkg::D_IDLE;
			end
		endcase
		stall_d = (ds_d != tsu_pkg::D_IDLE);
		irq12_d = |(rdf_d[1:0] & read_irq_en[1:0]) | |(wrf_d[1:0] & write_irq_en[1:0]);
		irq3_d = (rdf_d[2] & read_irq_en[2]) | (wrf_d[2] & write_irq_en[2]);
	end

	always_ff @(posedge clk) begin
		if (ce && a_we)
			ram_q[a_addr] <= a_dat;
		if (ce && b_we)
			ram_q[cpu_addr] <= cpu_wdata;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ds_q <= tsu_pkg::D_IDLE;
			ek_q <= tsu_pkg::EV_END;
			esl_q <= 2'h0;
			edat_q <= 8'h00;
			shr_q <= 8'h00;
			rsp_dat_q <= 8'hFF;
			rsp_tgl_q <= 1'b0;
			wsh_q <= 8'h00;
			wsa_q <= 10'h000;
			da_q <= 10'h000;
			da2_q <= 10'h000;
			cur_q <= '{default: tsu_pkg::ADDR_RST};
			cnt_q <= '{default: tsu_pkg::CNT_RST};
			pend_q <= 1'b0;
			pair_q <= 1'b0;
			stall_q <= 1'b0;
			dreq_q <= 1'b0;
			hold_q <= 1'b0;
			wmode_q <= 1'b0;
			wfull_q <= 1'b0;
			wb_q <= 1'b0;
			rdf_q <= 3'h0;
			wrf_q <= 3'h0;
			wrote_q <= 3'h0;
			irq12_q <= 1'b0;
			irq3_q <= 1'b0;
			rdata_q <= 8'h00;
		end else if (ce) begin
			ds_q <= ds_d;
			ek_q <= ek_d;
			esl_q <= esl_d;
			edat_q <= edat_d;
			shr_q <= shr_d;
			rsp_dat_q <= rsp_dat_d;
			rsp_tgl_q <= rsp_tgl_d;
			wsh_q <= wsh_d;
			wsa_q <= wsa_d;
			da_q <= da_d;
			da2_q <= da2_d;
			cur_q <= cur_d;
			cnt_q <= cnt_d;
			pend_q <= pend_d;
			pair_q <= pair_d;
			stall_q <= stall_d;
			dreq_q <= dreq_d;
			hold_q <= hold_d;
			wmode_q <= wmode_d;
			wfull_q <= wfull_d;
			wb_q <= wb_d;
			rdf_q <= rdf_d;
			wrf_q <= wrf_d;
			wrote_q <= wrote_d;
			irq12_q <= irq12_d;
			irq3_q <= irq3_d;
			rdata_q <= rdata_d;
		end
	end

	assign cpu_rdata = rdata_q;
	assign cpu_stall = stall_q;
	assign dma_req = dreq_q;
	assign read_done_flag = rdf_q;
	assign write_done_flag = wrf_q;
	assign write_hold_flag = hold_q;
	assign word_mode = wmode_q;
	assign bus_busy = busy_s_q[1];
	assign irq_slaves12 = irq12_q;
	assign irq_slave3 = irq3_q;
endmodule : tsu_triple_slave
`default_nettype wire

//--- verification/tsu_triple_slave_props.sv
// Purpose: Concurrent checks on the triple slave unit ports
// Assumes: Single clk domain view; rst synchronous active high
// Notes: Attached by bind below the module
`timescale 1ns/1ps
`default_nettype none
module tsu_triple_slave_props #(
	parameter int BUF3_BYTES = 128
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cpu_we,
	input wire logic [9:0] cpu_addr,
	input wire logic cpu_stall,
	input wire logic dma_req,
	input wire logic cr2_wr,
	input wire logic cr2_word_mode,
	input wire logic cr2_write_hold,
	input wire logic word_mode,
	input wire logic write_hold_flag,
	input wire logic status_rd,
	input wire logic bus_busy,
	input wire logic [2:0] read_done_flag,
	input wire logic [2:0] write_done_flag,
	input wire logic [2:0] read_irq_en,
	input wire logic [2:0] write_irq_en,
	input wire logic irq_slaves12,
	input wire logic irq_slave3
);
	// ==========
	// Helpers
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	logic pend12;
	logic pend3;
	assign pend12 = |((read_done_flag[1:0] & read_irq_en[1:0]) |
		(write_done_flag[1:0] & write_irq_en[1:0]));
	assign pend3 = (read_done_flag[2] & read_irq_en[2]) | (write_done_flag[2] & write_irq_en[2]);
	sequence even_wr_s;
		word_mode && cpu_we && !cpu_stall && !cpu_addr[0];
	endsequence
	sequence odd_wr_s;
		word_mode && cpu_we && !cpu_stall && cpu_addr[0];
	endsequence
	// ==========
	// Properties
	stall_bound_a: assert property (cpu_stall [*2] |=> !cpu_stall)
		else $error("stall longer than two cycles");
	dma_pulse_a: assert property (dma_req |=> !dma_req)
		else $error("dma request not a single pulse");
	irq_pair_a: assert property (pend12 == $past(pend12) |-> irq_slaves12 == pend12)
		else $error("shared interrupt line wrong");
	irq_third_a: assert property (pend3 == $past(pend3) |-> irq_slave3 == pend3)
		else $error("slave three interrupt wrong");
	hold_keep_a: assert property (cr2_wr && cr2_write_hold && write_hold_flag |=> write_hold_flag)
		else $error("write hold lost on one");
	hold_clear_a: assert property (cr2_wr && !cr2_write_hold && write_hold_flag |=> !write_hold_flag)
		else $error("write hold not cleared");
	word_set_a: assert property (cr2_wr && cr2_word_mode |=> word_mode)
		else $error("word mode not set");
	word_end_a: assert property (even_wr_s ##1 odd_wr_s |-> ##[1:3] !word_mode)
		else $error("word mode not cleared");
	word_dma_a: assert property (even_wr_s ##1 odd_wr_s |=>
		!dma_req ##1 (!dma_req && !cpu_stall))
		else $error("dma during shadow write");
	status_clr_a: assert property (status_rd && !bus_busy |=>
		((read_done_flag & $past(read_done_flag)) == 3'h0) &&
		((write_done_flag & $past(write_done_flag)) == 3'h0))
		else $error("status read left flags set");
endmodule : tsu_triple_slave_props
bind tsu_triple_slave tsu_triple_slave_props #(.BUF3_BYTES(BUF3_BYTES)) u_tsu_triple_slave_props (
	.clk, .rst, .cpu_we, .cpu_addr, .cpu_stall, .dma_req, .cr2_wr, .cr2_word_mode,
	.cr2_write_hold, .word_mode, .write_hold_flag, .status_rd, .bus_busy, .read_done_flag,
	.write_done_flag, .read_irq_en, .write_irq_en, .irq_slaves12, .irq_slave3
);
`default_nettype wire

//--- verification/tsu_i2c_master.sv
// Purpose: External bus master model for the triple slave unit
// Assumes: Bench resolves the open drain data line with a pull-up
// Notes: SCL stands high between frames, half period H
`timescale 1ns/1ps
`default_nettype none
module tsu_i2c_master #(
	parameter int H = 1000
) (
	output logic scl,
	output logic sda_drv,
	input wire logic sda_line
);
	// ==========
	// Bus cycles
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		#(H / 2);
		scl = 1'b1;
		#(H / 2);
		r = sda_line;
		#(H / 2);
		scl = 1'b0;
		#(H / 2);
	endtask : bit_io
	task automatic start();
		sda_drv = 1'b1;
		#(H / 2);
		scl = 1'b1;
		#(H / 2);
		sda_drv = 1'b0;
		#(H / 2);
		scl = 1'b0;
		#(H / 2);
	endtask : start
	task automatic stop();
		sda_drv = 1'b0;
		#(H / 2);
		scl = 1'b1;
		#(H / 2);
		sda_drv = 1'b1;
		#(H / 2);
	endtask : stop
	task automatic wr_byte(input logic [7:0] d, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, ack_n);
	endtask : wr_byte
	task automatic rd_byte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(nack, r);
	endtask : rd_byte
endmodule : tsu_i2c_master
`default_nettype wire

//--- verification/tsu_triple_slave_test.sv
// Purpose: Self-checking bench of the triple slave unit
// Assumes: Master model half period of 1 us
// Notes: RAM contents predicted by a byte array model
`timescale 1ns/1ps
`default_nettype none
module tsu_triple_slave_test;
	logic clk, link_clk, rst, ce, scl_i, sda_i, sda_o, sda_oe_n, sda_drv;
	logic [7:0] slave_one_address_reg, slave_two_address_reg, slave_three_address_reg, cpu_wdata;
	logic [7:0] cpu_rdata;
	logic [1:0] page_length_select;
	logic buffer_one_write_lock, buffer_two_write_lock, cr2_wr, cr2_word_mode, cr2_write_hold;
	logic status_rd, cpu_we, cpu_stall, dma_req, write_hold_flag, word_mode, bus_busy;
	logic irq_slaves12, irq_slave3;
	logic [2:0] read_irq_en, write_irq_en, read_done_flag, write_done_flag;
	logic [9:0] cpu_addr;
	logic [7:0] mem [640];
	logic [6:0] sa_tab [3] = '{7'h50, 7'h51, 7'h52};
	logic [31:0] seed = 32'h57383430;
	int cur [3];
	int num_errors = 0;
	int n_checks = 0;
	int n_dma = 0;
	always #5 clk = ~clk;
	always #3 link_clk = ~link_clk;
	assign sda_i = sda_drv & (sda_oe_n | sda_o);
	always @(posedge clk) if (dma_req === 1'b1) n_dma++;
	tsu_triple_slave u_tsu_triple_slave (.clk, .rst, .ce, .link_clk, .scl_i, .sda_i, .sda_o,
		.sda_oe_n, .slave_one_address_reg, .slave_two_address_reg, .slave_three_address_reg,
		.page_length_select, .buffer_one_write_lock, .buffer_two_write_lock, .read_irq_en,
		.write_irq_en, .cr2_wr, .cr2_word_mode, .cr2_write_hold, .status_rd, .cpu_we, .cpu_addr,
		.cpu_wdata, .cpu_rdata, .cpu_stall, .dma_req, .read_done_flag, .write_done_flag,
		.write_hold_flag, .word_mode, .bus_busy, .irq_slaves12, .irq_slave3);
	tsu_i2c_master u_tsu_i2c_master (.scl(scl_i), .sda_drv, .sda_line(sda_i));
	// ==========
	// Tasks
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic cyc();
		@(posedge clk);
		#1;
	endtask : cyc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude
	task automatic flags(input logic [7:0] f, input logic [7:0] m);
		chk({2'h0, read_done_flag, write_done_flag}, f);
		chk({4'h0, write_hold_flag, word_mode, irq_slaves12, irq_slave3}, m);
	endtask : flags
	task automatic cpu_wr(input logic [9:0] a, input logic [7:0] d);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_we = 1'b1;
		cyc();
		mem[a] = d;
	endtask : cpu_wr
	task automatic ram_chk(input logic [9:0] a);
		cpu_addr = a;
		cyc();
		chk(cpu_rdata, mem[a]);
	endtask : ram_chk
	task automatic cr2(input logic w, input logic h);
		cr2_wr = 1'b1;
		cr2_word_mode = w;
		cr2_write_hold = h;
		cyc();
		cr2_wr = 1'b0;
		cyc();
	endtask : cr2
	task automatic status();
		status_rd = 1'b1;
		cyc();
		status_rd = 1'b0;
		cyc();
	endtask : status
	task automatic settle();
		int i;
		for (i = 0; i < 400 && bus_busy !== 1'b0; i++) cyc();
		if (i == 400) begin
			chk(8'(bus_busy), 8'h00);
			conclude();
		end
		repeat (10) cyc();
	endtask : settle
	task automatic addr_only(input logic [7:0] b, input logic exp_n);
		logic a;
		u_tsu_i2c_master.start();
		u_tsu_i2c_master.wr_byte(b, a);
		chk(8'(a), 8'(exp_n));
		u_tsu_i2c_master.stop();
		settle();
	endtask : addr_only
	task automatic i2c_wr(input int s, input logic [7:0] ba, input int n, input logic [7:0] pm,
		input logic keep);
		logic a;
		logic [7:0] d;
		int ad;
		u_tsu_i2c_master.start();
		u_tsu_i2c_master.wr_byte({sa_tab[s], 1'b0}, a);
		chk(8'(a), 8'h00);
		u_tsu_i2c_master.wr_byte(ba, a);
		ad = ba;
		for (int k = 0; k < n; k++) begin
			seed = lfsr_next(seed);
			d = seed[7:0];
			u_tsu_i2c_master.wr_byte(d, a);
			chk(8'(a), 8'h00);
			if (keep) mem[s * 256 + ad] = d;
			ad = (ad & ~32'(pm)) | ((ad + 1) & 32'(pm));
		end
		cur[s] = ad;
	endtask : i2c_wr
	task automatic i2c_rd(input int s, input int n);
		logic a;
		logic [7:0] d;
		u_tsu_i2c_master.start();
		u_tsu_i2c_master.wr_byte({sa_tab[s], 1'b1}, a);
		chk(8'(a), 8'h00);
		for (int k = 0; k < n; k++) begin
			u_tsu_i2c_master.rd_byte(k == n - 1, d);
			chk(d, mem[s * 256 + cur[s]]);
			cur[s] = (cur[s] + 1) % (s == 2 ? 128 : 256);
		end
		u_tsu_i2c_master.stop();
		settle();
	endtask : i2c_rd
	// ==========
	// Sequence
	initial begin
		#900000;
		chk(8'h00, 8'h01);
		conclude();
	end
	initial begin
		{clk, link_clk, rst, ce, cr2_wr, cr2_word_mode, cr2_write_hold} = 7'h19;
		{status_rd, cpu_we, cpu_addr, cpu_wdata, buffer_one_write_lock} = '0;
		buffer_two_write_lock = 1'b0;
		slave_one_address_reg = {sa_tab[0], 1'b1};
		slave_two_address_reg = {sa_tab[1], 1'b1};
		slave_three_address_reg = {sa_tab[2], 1'b1};
		page_length_select = tsu_pkg::PL_8;
		read_irq_en = 3'h7;
		write_irq_en = 3'h7;
		repeat (5) cyc();
		flags(8'h00, 8'h00);
		chk({sda_oe_n, cpu_stall, dma_req, cpu_rdata[4:0]}, 8'h80);
		rst = 1'b0;
		repeat (8) cyc();
		$display("test reset done");
		cpu_wr(10'h1F0, 8'h5A);
		cpu_wr(10'h1F1, 8'hC3);
		cpu_wr(10'h27F, 8'hA5);
		cpu_wr(10'h200, 8'h3C);
		cpu_wr(10'h201, 8'h96);
		cpu_we = 1'b0;
		cr2(1'b1, 1'b1);
		chk(8'(word_mode), 8'h01);
		cpu_wr(10'h204, 8'h11);
		cpu_wr(10'h205, 8'h22);
		cpu_we = 1'b0;
		cyc();
		cyc();
		chk(8'(word_mode), 8'h00);
		ram_chk(10'h204);
		ram_chk(10'h205);
		$display("test word done");
		n_dma = 0;
		i2c_wr(0, 8'h0C, 10, 8'h07, 1'b1);
		u_tsu_i2c_master.stop();
		settle();
		chk(8'(n_dma), 8'h0A);
		flags(8'h01, 8'h0A);
		for (int a = 8; a < 16; a++) ram_chk(10'(a));
		$display("test page done");
		addr_only({sa_tab[2], 1'b0}, 1'b1);
		status();
		flags(8'h00, 8'h08);
		cr2(1'b0, 1'b1);
		chk(8'(write_hold_flag), 8'h01);
		cr2(1'b0, 1'b0);
		chk(8'(write_hold_flag), 8'h00);
		$display("test hold done");
		buffer_two_write_lock = 1'b1;
		page_length_select = tsu_pkg::PL_16;
		i2c_wr(1, 8'hFF, 2, 8'h0F, 1'b0);
		u_tsu_i2c_master.stop();
		settle();
		flags(8'h00, 8'h00);
		ram_chk(10'h1F0);
		i2c_rd(1, 1);
		page_length_select = tsu_pkg::PL_FULL;
		i2c_wr(1, 8'hEF, 2, 8'hFF, 1'b0);
		i2c_rd(1, 1);
		flags(8'h10, 8'h02);
		$display("test lock done");
		status();
		n_dma = 0;
		i2c_wr(2, 8'h7F, 0, 8'h7F, 1'b1);
		i2c_rd(2, 3);
		chk(8'(n_dma), 8'h03);
		flags(8'h20, 8'h01);
		$display("test read done");
		status();
		slave_one_address_reg = {sa_tab[0], 1'b0};
		n_dma = 0;
		addr_only({sa_tab[0], 1'b0}, 1'b1);
		chk(8'(n_dma), 8'h00);
		flags(8'h00, 8'h00);
		$display("test disable done");
		conclude();
	end
endmodule : tsu_triple_slave_test
`default_nettype wire
